// >>> shared/dr_defines.svh
// Disturbance recorder constants: offsets, fields, resets, timing
// Operation
// RL1: Capture starts on manual request or when an enabled trigger input becomes active.
// RL2: Every binary channel is selectable as trigger; several may be enabled together.
// RL3: Never more than 100 stored recordings, however small each one is.
// RL4: An enable setting switches the whole recorder on or off.
// RL5: Status is ready, triggered, recording+storing, storing, full or bad config.
// RL6: Writing N to selective clear deletes the Nth stored recording, counting from one.
// RL7: Manual trigger starts a capture and returns to idle by itself.
// RL8: Clear-all deletes every stored recording.
// RL9: Clear-newest deletes only the most recently stored recording.
// RL10: Clear-oldest deletes only the earliest stored recording.
// RL11: Report how many recordings fit with current settings, 0 to 100.
// RL12: Report longest single recording in milliseconds, up to 1800 seconds.
// RL13: Report largest pre-trigger time the current settings permit.
// RL14: Report count of recordings held in memory, 0 to 100.
// RL15: Recording length settable 0.1 to 1800 s, default 1 s.
// RL16: When full, FIFO mode overwrites oldest; keep-oldest mode refuses new ones.
// RL17: Analog rate 64, 32, 16 or 8 samples per cycle, default 64.
// RL18: Binary channels are sampled at a fixed 5 ms interval.
// RL19: Pre-trigger time settable 0.2 to 15.0 s, default 0.2 s.
// RL20: At most 8 analog channels may be selected.
// RL21: At most 95 binary channels may be selected.
// RL22: Auto transfer pushes new recordings to a six-slot area; pushed ones leave the store.
// RL23: Not ready unless maximum recording length is nonzero; needs a trigger selected.
// RL24: Triggers while disabled, misconfigured or full in keep-oldest mode are ignored.
`ifndef DR_DEFINES_SVH
`define DR_DEFINES_SVH
`define DR_A_CTRL 8'h00
`define DR_A_CMD 8'h04
`define DR_A_CLRSEL 8'h08
`define DR_A_LEN 8'h0c
`define DR_A_PRE 8'h10
`define DR_A_ANSEL 8'h14
`define DR_A_DIG0 8'h18
`define DR_A_TRG0 8'h24
`define DR_A_STAT 8'h30
`define DR_A_CAP 8'h34
`define DR_A_MAXLEN 8'h38
`define DR_A_MAXPRE 8'h3c
`define DR_A_XFER 8'h40
`define DR_F_EN 0
`define DR_F_KEEP 1
`define DR_F_AUTO 2
`define DR_F_RATE 4
`define DR_F_TRG 0
`define DR_F_CLRALL 1
`define DR_F_CLRNEW 2
`define DR_F_CLROLD 3
`define DR_RST_LEN 32'h0000_03e8
`define DR_RST_PRE 32'h0000_00c8
`define DR_LEN_MIN 32'h0000_0064
`define DR_LEN_MAX 32'h001b_7740
`define DR_PRE_MIN 32'h0000_00c8
`define DR_PRE_MAX 32'h0000_3a98
`define DR_ST_READY 3'h0
`define DR_ST_TRIG 3'h1
`define DR_ST_RECSTO 3'h2
`define DR_ST_STORE 3'h3
`define DR_ST_FULL 3'h4
`define DR_ST_BAD 3'h5
`define DR_MAX_RECS 100
`define DR_XFER_SLOTS 6
`define DR_N_AN 20
`define DR_AN_MAX 8
`define DR_N_BIN 95
`define DR_FN_HZ 50
`define DR_BIN_HZ 200
`define DR_RESERVE 16076647
`define DR_CLK_MHZ 250
`define DR_TICK_NS 1000000
`define DR_BIN_MS 5
`define DR_STORE_MS 10
`endif

// >>> shared/dr_pkg.sv
// Types shared by the disturbance recorder design
package dr_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic {CAP_IDLE, CAP_POST} cap_state_e;
  typedef enum logic [1:0] {CALC_LEN, CALC_WLEN, CALC_REC, CALC_WREC} calc_state_e;
endpackage

// >>> rtl/dr_div.sv
// Sequential restoring divider used for the capacity estimates
`timescale 1ns/10ps
module dr_div #(
  parameter int W = 48
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  logic [W-1:0] rem_r;
  logic [W-1:0] den_r;
  logic [W-1:0] quo_r;
  logic [$clog2(W+1)-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [W:0] trial;

  if (W < 8 || W > 64) begin : g_bad_w
    $error("dr_div: W out of range");
  end

  assign trial = {rem_r, quo_r[W-1]} - {1'b0, den_r};
  assign busy = busy_r;
  assign done = done_r;
  assign quo = quo_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
      den_r <= '0;
      quo_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        rem_r <= '0;
        den_r <= den;
        quo_r <= num;
        cnt_r <= ($clog2(W+1))'(W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        // Zero divisor runs through and yields all ones, clamped by the caller
        if (!trial[W]) begin
          rem_r <= trial[W-1:0];
          quo_r <= {quo_r[W-2:0], 1'b1};
        end else begin
          rem_r <= {rem_r[W-2:0], quo_r[W-1]};
          quo_r <= {quo_r[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> rtl/dr_ctrl.sv
// Disturbance recorder control, trigger and store bookkeeping
`timescale 1ns/10ps
`include "dr_defines.svh"
module dr_ctrl #(
  parameter int MS_CYC = `DR_TICK_NS * `DR_CLK_MHZ / 1000,
  parameter int MAX_RECS = `DR_MAX_RECS,
  parameter int XFER_SLOTS = `DR_XFER_SLOTS,
  parameter int N_AN = `DR_N_AN,
  parameter int N_BIN = `DR_N_BIN
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire dr_pkg::word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output dr_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_BIN-1:0] bin_in,
  output logic bin_smp,
  output logic [1:0] an_rate,
  output logic [N_AN-1:0] an_sel,
  output logic [N_BIN-1:0] bin_sel,
  output logic rec_act,
  output logic store_wr,
  output logic [6:0] store_slot,
  output logic del_pls,
  output logic del_all,
  output logic [31:0] del_pos,
  output logic xfer_push
);
  import dr_pkg::*;
  localparam int W = 48;
  localparam int BIN_CYC = `DR_BIN_MS * MS_CYC;
  localparam logic [W-1:0] NUM_MS = W'(64'(`DR_RESERVE) * 64'd1000);

  // Upper selection bits are cleared by slice, so at most 95 binary channels fit
  if (MAX_RECS < 1 || MAX_RECS > `DR_MAX_RECS || N_BIN < 1 || N_BIN > 95 || N_AN > 32
      || XFER_SLOTS < 1 || XFER_SLOTS > 15 || MS_CYC < 1) begin : g_bad_par
    $error("dr_ctrl: parameter out of range");
  end

  function automatic logic [6:0] popcnt(input logic [95:0] v);
    logic [6:0] n;
    n = '0;
    for (int i = 0; i < 96; i++) n = n + 7'(v[i]);
    return n;
  endfunction

  function automatic word_t wmerge(input word_t old, input word_t nw, input logic [3:0] st);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `DR_A_XFER;
  endfunction

  // Bus slave
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  word_t wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  word_t rd_mux;
  wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  wire rd_go = s_axi_arvalid && !rvalid_r;
  wire [95:0] wd0 = 96'(wmerge('0, wdata_r, wstrb_r));

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= 2'h0;
      rresp_r <= 2'h0;
      rdata_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Settings
  logic [5:0] ctrl_r;
  word_t len_r, pre_r;
  logic [N_AN-1:0] an_r;
  logic [95:0] dig_r, trg_r;
  wire word_t ctrl_mrg = wmerge(32'(ctrl_r), wdata_r, wstrb_r);
  wire wr_ctrl = wr_go && awaddr_r == `DR_A_CTRL;
  wire wr_cmd = wr_go && awaddr_r == `DR_A_CMD;
  wire wr_sel = wr_go && awaddr_r == `DR_A_CLRSEL;
  wire wr_xfer = wr_go && awaddr_r == `DR_A_XFER;
  wire en = ctrl_r[`DR_F_EN]; // RL4
  wire keep = ctrl_r[`DR_F_KEEP];
  wire auto_on = ctrl_r[`DR_F_AUTO];
  // Command bits are pulses only; the register reads back idle
  wire man_trg = wr_cmd && wd0[`DR_F_TRG]; // RL7
  wire clr_all = wr_cmd && wd0[`DR_F_CLRALL];
  wire clr_new = wr_cmd && wd0[`DR_F_CLRNEW];
  wire clr_old = wr_cmd && wd0[`DR_F_CLROLD];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= '0; // RL16 RL17
      len_r <= `DR_RST_LEN; // RL15
      pre_r <= `DR_RST_PRE; // RL19
      an_r <= '0;
      dig_r <= '0;
      trg_r <= '0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_r <= ctrl_mrg[5:0];
      if (wr_go && awaddr_r == `DR_A_LEN) len_r <= wmerge(len_r, wdata_r, wstrb_r);
      if (wr_go && awaddr_r == `DR_A_PRE) pre_r <= wmerge(pre_r, wdata_r, wstrb_r);
      if (wr_go && awaddr_r == `DR_A_ANSEL)
        an_r <= N_AN'(wmerge(32'(an_r), wdata_r, wstrb_r));
      for (int k = 0; k < 3; k++) begin
        if (wr_go && awaddr_r == `DR_A_DIG0 + 8'(4 * k))
          dig_r[32*k +: 32] <= wmerge(dig_r[32*k +: 32], wdata_r, wstrb_r);
        if (wr_go && awaddr_r == `DR_A_TRG0 + 8'(4 * k))
          trg_r[32*k +: 32] <= wmerge(trg_r[32*k +: 32], wdata_r, wstrb_r); // RL2
      end
      dig_r[95:N_BIN] <= '0;
      trg_r[95:N_BIN] <= '0;
    end
  end

  assign an_rate = ctrl_r[`DR_F_RATE +: 2]; // RL17
  assign an_sel = an_r;
  assign bin_sel = dig_r[N_BIN-1:0];

  // Capacity estimates
  logic [W-1:0] max_len_r, max_recs_r, div_q;
  logic div_busy, div_done;
  calc_state_e calc_r;
  wire [6:0] n_an = popcnt(96'(an_r));
  wire [6:0] n_dig = popcnt(dig_r);
  wire [W-1:0] sr = W'(64) >> an_rate;
  wire [W-1:0] rate = W'(`DR_FN_HZ) * (W'(n_an) + 1'b1) * sr
    + W'(`DR_BIN_HZ) * W'(n_dig); // RL18
  wire calc_rec = calc_r == CALC_REC || calc_r == CALC_WREC;
  wire [W-1:0] div_den = calc_rec ? rate * W'(len_r) : rate;
  wire div_go = calc_r == CALC_LEN || calc_r == CALC_REC;
  wire [31:0] max_len = 32'(max_len_r);
  wire [31:0] max_pre = max_len < `DR_PRE_MAX ? max_len : `DR_PRE_MAX; // RL13
  wire [31:0] cap = 32'(max_recs_r);

  dr_div #(.W(W)) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(div_go),
    .num(NUM_MS),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quo(div_q)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calc_r <= CALC_LEN;
      max_len_r <= '0;
      max_recs_r <= '0;
    end else if (ce) begin
      case (calc_r)
        CALC_LEN: if (!div_busy) calc_r <= CALC_WLEN;
        CALC_WLEN: if (div_done) begin
          calc_r <= CALC_REC;
          if (trg_r == '0) max_len_r <= '0; // RL23
          else max_len_r <= div_q > W'(`DR_LEN_MAX) ? W'(`DR_LEN_MAX) : div_q; // RL12
        end
        CALC_REC: if (!div_busy) calc_r <= CALC_WREC;
        CALC_WREC: if (div_done) begin
          calc_r <= CALC_LEN;
          max_recs_r <= div_q > W'(MAX_RECS) ? W'(MAX_RECS) : div_q; // RL11
        end
        default: calc_r <= CALC_LEN;
      endcase
    end
  end

  wire cfg_bad = len_r < `DR_LEN_MIN || len_r > `DR_LEN_MAX // RL15
    || pre_r < `DR_PRE_MIN || pre_r > `DR_PRE_MAX || pre_r >= len_r // RL19
    || n_an > 7'(`DR_AN_MAX) || n_dig > 7'(`DR_N_BIN) // RL20 RL21
    || max_len == '0 || len_r > max_len; // RL23

  // Millisecond and binary sample ticks
  logic [$clog2(MS_CYC+1)-1:0] ms_cnt_r;
  logic [$clog2(BIN_CYC+1)-1:0] bin_cnt_r;
  logic bin_smp_r;
  wire ms_tick = ms_cnt_r == '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= '0;
      bin_cnt_r <= '0;
      bin_smp_r <= 1'b0;
    end else if (ce) begin
      ms_cnt_r <= ms_tick ? ($clog2(MS_CYC+1))'(MS_CYC - 1) : ms_cnt_r - 1'b1;
      bin_cnt_r <= bin_cnt_r == '0 ? ($clog2(BIN_CYC+1))'(BIN_CYC - 1) : bin_cnt_r - 1'b1;
      bin_smp_r <= en && bin_cnt_r == '0; // RL18
    end
  end
  assign bin_smp = bin_smp_r;

  // Capture and store sequencing
  cap_state_e cap_r;
  word_t post_r;
  logic [7:0] store_ms_r;
  logic store_busy_r;
  logic [N_BIN-1:0] bin_q_r;
  logic [6:0] cnt_r, head_r, cnt_nxt, head_nxt;
  logic [3:0] xfer_r, xfer_nxt;
  logic sw_nxt, del_nxt, dall_nxt, push_nxt;
  logic [6:0] slot_nxt;
  word_t dpos_nxt;
  wire full = 32'(cnt_r) >= cap;
  wire auto_hit = |(bin_in & ~bin_q_r & trg_r[N_BIN-1:0]); // RL1 RL2
  wire trg_ok = en && !cfg_bad && !(full && keep) && cap_r == CAP_IDLE; // RL24
  wire trg_go = trg_ok && (man_trg || auto_hit); // RL1 RL7
  wire post_end = cap_r == CAP_POST && post_r == '0 && !store_busy_r;
  // Gated by enable so a store cut short by switching off never commits
  wire store_done = en && store_busy_r && store_ms_r == '0 && ms_tick; // RL4
  wire [7:0] tail_sum = 8'(head_r) + 8'(cnt_r);
  wire [6:0] tail = tail_sum >= 8'(MAX_RECS) ? 7'(tail_sum - 8'(MAX_RECS)) : tail_sum[6:0];
  wire [6:0] head_inc = head_r == 7'(MAX_RECS - 1) ? 7'h00 : head_r + 7'h01;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= CAP_IDLE;
      post_r <= '0;
      store_ms_r <= '0;
      store_busy_r <= 1'b0;
      bin_q_r <= '0;
    end else if (ce) begin
      bin_q_r <= bin_in;
      if (!en) begin
        // Switching off abandons any capture in flight
        cap_r <= CAP_IDLE;
        store_busy_r <= 1'b0;
      end else begin
        case (cap_r)
          CAP_IDLE: if (trg_go) begin
            cap_r <= CAP_POST;
            post_r <= len_r - pre_r;
          end
          CAP_POST: begin
            if (post_r != '0 && ms_tick) post_r <= post_r - 1'b1;
            if (post_end) begin
              cap_r <= CAP_IDLE;
              store_busy_r <= 1'b1;
              store_ms_r <= 8'(`DR_STORE_MS - 1);
            end
          end
          default: cap_r <= CAP_IDLE;
        endcase
        if (store_busy_r && ms_tick) begin
          if (store_ms_r == '0) store_busy_r <= 1'b0;
          else store_ms_r <= store_ms_r - 1'b1;
        end
      end
    end
  end
  assign rec_act = cap_r == CAP_POST;

  always_comb begin
    cnt_nxt = cnt_r;
    head_nxt = head_r;
    xfer_nxt = xfer_r;
    sw_nxt = 1'b0;
    slot_nxt = store_slot;
    push_nxt = 1'b0;
    del_nxt = 1'b0;
    dall_nxt = 1'b0;
    dpos_nxt = del_pos;
    if (wr_xfer && xfer_r != '0) xfer_nxt = xfer_r - 1'b1;
    if (store_done) begin
      if (auto_on && xfer_nxt < 4'(XFER_SLOTS)) begin
        push_nxt = 1'b1; // RL22
        xfer_nxt = xfer_nxt + 1'b1;
      end else if (!full) begin
        sw_nxt = 1'b1;
        slot_nxt = tail;
        cnt_nxt = cnt_r + 1'b1; // RL3
      end else if (!keep) begin
        sw_nxt = 1'b1; // RL16
        slot_nxt = head_r;
        head_nxt = head_inc;
      end
    end
    if (clr_all) begin
      cnt_nxt = '0; // RL8
      head_nxt = '0;
      del_nxt = 1'b1;
      dall_nxt = 1'b1;
    end else if (clr_new && cnt_nxt != '0) begin
      cnt_nxt = cnt_nxt - 1'b1; // RL9
      del_nxt = 1'b1;
      dpos_nxt = 32'(cnt_nxt) + 32'h1;
    end else if ((clr_old || (wr_sel && wd0[31:0] == 32'h1)) && cnt_nxt != '0) begin
      cnt_nxt = cnt_nxt - 1'b1; // RL10
      head_nxt = head_nxt == 7'(MAX_RECS - 1) ? 7'h00 : head_nxt + 7'h01;
      del_nxt = 1'b1;
      dpos_nxt = 32'h1;
    end else if (wr_sel && wd0[31:0] > 32'h1 && wd0[31:0] <= 32'(cnt_nxt)) begin
      cnt_nxt = cnt_nxt - 1'b1; // RL6
      del_nxt = 1'b1;
      dpos_nxt = wd0[31:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      head_r <= '0;
      xfer_r <= '0;
      store_wr <= 1'b0;
      store_slot <= '0;
      xfer_push <= 1'b0;
      del_pls <= 1'b0;
      del_all <= 1'b0;
      del_pos <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      head_r <= head_nxt;
      xfer_r <= xfer_nxt;
      store_wr <= sw_nxt;
      store_slot <= slot_nxt;
      xfer_push <= push_nxt;
      del_pls <= del_nxt;
      del_all <= dall_nxt;
      del_pos <= dpos_nxt;
    end
  end

  // Status and readback
  wire [2:0] status = cfg_bad ? `DR_ST_BAD // RL5
    : rec_act && store_busy_r ? `DR_ST_RECSTO
    : rec_act ? `DR_ST_TRIG
    : store_busy_r ? `DR_ST_STORE
    : full && keep ? `DR_ST_FULL : `DR_ST_READY;

  always_comb begin
    rd_mux = '0;
    case (s_axi_araddr)
      `DR_A_CTRL: rd_mux = 32'(ctrl_r);
      `DR_A_CLRSEL, `DR_A_CMD: rd_mux = '0;
      `DR_A_LEN: rd_mux = len_r;
      `DR_A_PRE: rd_mux = pre_r;
      `DR_A_ANSEL: rd_mux = 32'(an_r);
      `DR_A_DIG0: rd_mux = dig_r[31:0];
      `DR_A_DIG0 + 8'h04: rd_mux = dig_r[63:32];
      `DR_A_DIG0 + 8'h08: rd_mux = dig_r[95:64];
      `DR_A_TRG0: rd_mux = trg_r[31:0];
      `DR_A_TRG0 + 8'h04: rd_mux = trg_r[63:32];
      `DR_A_TRG0 + 8'h08: rd_mux = trg_r[95:64];
      `DR_A_STAT: rd_mux = {16'h0, 1'b0, cnt_r, 5'h0, status}; // RL14
      `DR_A_CAP: rd_mux = cap;
      `DR_A_MAXLEN: rd_mux = max_len;
      `DR_A_MAXPRE: rd_mux = max_pre;
      `DR_A_XFER: rd_mux = 32'(xfer_r);
      default: rd_mux = '0;
    endcase
  end

  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [$clog2(BIN_CYC+1):0] gap_r;
  logic seen_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (ce) begin
      gap_r <= bin_smp_r ? ($bits(gap_r))'(1) : gap_r + 1'b1;
      // Spacing restarts after an off period
      seen_r <= en && (seen_r | bin_smp_r);
    end
  end

  rec_count_cap_a: assert property (cnt_r <= 7'(MAX_RECS) && 32'(cnt_r) <= 32'(MAX_RECS)) // RL3
    else $error("stored count above limit");
  man_trig_start_a: assert property (ce && man_trg && trg_ok |=> rec_act) // RL7
    else $error("manual trigger did not start capture");
  keep_full_ign_a: assert property (ce && en && keep && full && !rec_act
    |=> !rec_act) // RL24
    else $error("trigger taken while full in keep mode");
  off_no_store_a: assert property (!en |=> !store_wr && !xfer_push && !rec_act) // RL4
    else $error("activity while disabled");
  clear_all_a: assert property (ce && clr_all |=> cnt_r == '0 && del_all) // RL8
    else $error("clear all left recordings");
  bin_period_a: assert property (bin_smp_r && seen_r && ce && $past(ce)
    |-> gap_r == ($bits(gap_r))'(BIN_CYC) || !$stable(en)) // RL18
    else $error("binary sample spacing wrong");
  xfer_limit_a: assert property (xfer_r <= 4'(XFER_SLOTS)) // RL22
    else $error("transfer area overfilled");
  ready_len_a: assert property (status == `DR_ST_READY |-> max_len != '0) // RL23
    else $error("ready with zero max length");
  fifo_over_a: assert property (ce && store_done && full && !keep && !auto_on
    && !wr_cmd && !wr_sel |=> store_wr && cnt_r == $past(cnt_r)) // RL16
    else $error("fifo overwrite did not keep count");

  cap_start_c: cover property (ce && trg_go);
  store_c: cover property (store_wr);
  push_c: cover property (xfer_push);
  del_c: cover property (del_pls && !del_all);
endmodule

// >>> test/dr_bin_src.sv
// Binary signal source standing in for the protection logic outputs
`timescale 1ns/10ps
module dr_bin_src #(
  parameter int N = 95
) (
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [6:0] ch,
  output logic [N-1:0] bin_in
);
  initial bin_in = '0;
  // Held while requested so the recorder sees one clean rising edge
  always @(posedge clk_sys) begin
    bin_in <= fire ? (N'(1) << ch) : '0;
  end
endmodule

// >>> test/test_disturbance_recorder_control.sv
// Self-checking bench for the disturbance recorder control block
`timescale 1ns/10ps
`include "dr_defines.svh"
module test_disturbance_recorder_control;
  import dr_pkg::*;
  localparam int MS = 8;
  typedef struct {logic w; logic [7:0] a; word_t d; word_t e; logic [1:0] r;} row_s;
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, fire = 1'b0;
  logic [6:0] ch = 7'h00;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  word_t wdata = 32'h0, rdata, last_pos;
  logic awready, wready, bvalid, arready, rvalid, bin_smp, rec_act, store_wr, del_pls;
  logic del_all, xfer_push, rec_q = 1'b0, last_all;
  logic [1:0] bresp, rresp, an_rate, r;
  logic [19:0] an_sel;
  logic [94:0] bin_in, bin_sel;
  logic [6:0] store_slot;
  word_t del_pos, d;
  int err_total = 0, total_checks = 0, cyc = 0, n_st = 0, n_x = 0, n_del = 0, n_rec = 0;
  int last_smp = 0, smp_gap = 0;
  row_s rows[13] = '{
    '{0, `DR_A_CTRL, 0, 32'h0, 2'h0},
    '{0, `DR_A_LEN, 0, `DR_RST_LEN, 2'h0},
    '{0, `DR_A_PRE, 0, `DR_RST_PRE, 2'h0},
    '{0, 8'h44, 0, 32'h0, 2'h2},
    '{1, 8'h44, 32'h1, 32'h0, 2'h2},
    '{0, 8'h02, 0, 32'h0, 2'h2},
    '{0, `DR_A_STAT, 0, 32'h5, 2'h0},
    '{1, `DR_A_TRG0, 32'h3, 32'h0, 2'h0},
    '{1, `DR_A_LEN, 32'hc9, 32'h0, 2'h0},
    '{0, `DR_A_LEN, 0, 32'hc9, 2'h0},
    '{1, `DR_A_DIG0, 32'h5, 32'h0, 2'h0},
    '{1, `DR_A_CTRL, 32'h31, 32'h0, 2'h0},
    '{0, `DR_A_CTRL, 0, 32'h31, 2'h0}};
  dr_ctrl #(.MS_CYC(MS)) dr_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bin_in(bin_in), .bin_smp(bin_smp), .an_rate(an_rate), .an_sel(an_sel),
    .bin_sel(bin_sel), .rec_act(rec_act), .store_wr(store_wr), .store_slot(store_slot),
    .del_pls(del_pls), .del_all(del_all), .del_pos(del_pos), .xfer_push(xfer_push));
  dr_bin_src dr_bin_src_inst (.clk_sys(clk_sys), .fire(fire), .ch(ch), .bin_in(bin_in));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rec_q <= rec_act;
    if (store_wr === 1'b1) n_st <= n_st + 1;
    if (xfer_push === 1'b1) n_x <= n_x + 1;
    if (rec_act === 1'b1 && rec_q !== 1'b1) n_rec <= n_rec + 1;
    if (del_pls === 1'b1) begin
      n_del <= n_del + 1;
      last_pos <= del_pos;
      last_all <= del_all;
    end
    if (bin_smp === 1'b1) begin
      smp_gap <= cyc - last_smp;
      last_smp <= cyc;
    end
    if (cyc == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t v);
    @(posedge clk_sys);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge clk_sys); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge clk_sys); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    r = bresp; bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input word_t e);
    rd(a); chk(d, e); chk(32'(r), 32'h0);
  endtask
  task automatic cap();
    int s;
    s = n_st + n_x;
    wr(`DR_A_CMD, 32'h1);
    while (n_st + n_x == s) @(posedge clk_sys);
  endtask
  function automatic word_t st(input int n, input logic [2:0] s);
    return (32'(n) << 8) | 32'(s);
  endfunction
  initial begin
    repeat (8) @(posedge clk_sys);
    chk(32'(rec_act), 32'h0); chk(32'(an_rate), 32'h0);
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin rd(rows[i].a); chk(d, rows[i].e); end
      chk(32'(r), 32'(rows[i].r));
    end
    $display("test register map done");
    repeat (200) @(posedge clk_sys);
    chk(32'(an_rate), 32'h3);
    chk(bin_sel[31:0], 32'h5);
    chk(32'(smp_gap), 32'(5 * MS));
    rchk(`DR_A_STAT, st(0, `DR_ST_READY));
    rchk(`DR_A_CAP, 32'h64);
    rchk(`DR_A_MAXLEN, `DR_LEN_MAX);
    rchk(`DR_A_MAXPRE, `DR_PRE_MAX);
    cap();
    chk(32'(n_rec), 32'h1);
    rchk(`DR_A_CMD, 32'h0);
    rchk(`DR_A_STAT, st(1, `DR_ST_READY));
    ch <= 7'h01; fire <= 1'b1;
    while (n_st < 2) @(posedge clk_sys);
    fire <= 1'b0;
    chk(32'(n_rec), 32'h2);
    chk(32'(store_slot), 32'h1);
    $display("test triggers done");
    wr(`DR_A_CMD, 32'h4);
    rchk(`DR_A_STAT, st(1, `DR_ST_READY));
    chk(last_pos, 32'h2);
    cap(); cap();
    wr(`DR_A_CMD, 32'h8);
    rchk(`DR_A_STAT, st(2, `DR_ST_READY));
    chk(last_pos, 32'h1);
    wr(`DR_A_CLRSEL, 32'h2);
    rchk(`DR_A_STAT, st(1, `DR_ST_READY));
    chk(last_pos, 32'h2);
    wr(`DR_A_CLRSEL, 32'h5);
    chk(32'(n_del), 32'h3);
    wr(`DR_A_CMD, 32'h2);
    rchk(`DR_A_STAT, st(0, `DR_ST_READY));
    chk(32'(last_all), 32'h1);
    $display("test clears done");
    repeat (101) cap();
    rchk(`DR_A_STAT, st(100, `DR_ST_READY));
    chk(32'(n_st), 32'd105);
    wr(`DR_A_CTRL, 32'h33);
    repeat (200) @(posedge clk_sys);
    rchk(`DR_A_STAT, st(100, `DR_ST_FULL));
    wr(`DR_A_CMD, 32'h1);
    repeat (200) @(posedge clk_sys);
    chk(32'(n_rec), 32'd105);
    $display("test full memory done");
    wr(`DR_A_CMD, 32'h2);
    wr(`DR_A_CTRL, 32'h35);
    repeat (200) @(posedge clk_sys);
    repeat (7) cap();
    chk(32'(n_x), 32'h6);
    rchk(`DR_A_XFER, 32'h6);
    wr(`DR_A_XFER, 32'h0);
    rchk(`DR_A_XFER, 32'h5);
    rchk(`DR_A_STAT, st(1, `DR_ST_READY));
    wr(`DR_A_CMD, 32'h1);
    ce <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk(32'(rec_act), 32'h1);
    chk(32'(n_x), 32'h6);
    ce <= 1'b1;
    while (n_x < 7) @(posedge clk_sys);
    $display("test clock enable done");
    wr(`DR_A_CTRL, 32'h0);
    wr(`DR_A_CMD, 32'h1);
    repeat (200) @(posedge clk_sys);
    chk(32'(n_rec), 32'd113);
    wr(`DR_A_ANSEL, 32'h1ff);
    wr(`DR_A_CTRL, 32'h1);
    repeat (200) @(posedge clk_sys);
    chk(32'(an_sel), 32'h1ff);
    rchk(`DR_A_STAT, st(1, `DR_ST_BAD));
    $display("test modes done");
    end_of_test();
  end
endmodule
